/* File: shared/ldss_pkg.sv */
/*
  Package for the table-driven DAC source selector: register offsets,
  field positions, reset values and structs shared by the design.
  Assumes a byte-wide register port with one-cycle read latency.
*/
package ldss_pkg;

  localparam logic [8:0] LDSS_CTRL0_OFS = 9'h080;
  localparam logic [8:0] LDSS_CTRL1_OFS = 9'h081;
  localparam logic [8:0] LDSS_CTRL2_OFS = 9'h082;
  localparam logic [8:0] LDSS_CTRL3_OFS = 9'h083;
  localparam logic [8:0] LDSS_CTRL4_OFS = 9'h084;
  localparam logic [8:0] LDSS_CTRL5_OFS = 9'h085;
  localparam logic [8:0] LDSS_RESULT_OFS = 9'h087;
  localparam logic [8:0] LDSS_TAB1_BASE = 9'h090;
  localparam logic [8:0] LDSS_TAB2_BASE = 9'h0D0;
  localparam logic [8:0] LDSS_TAB2_END = 9'h10F;

  // Control 0 field positions
  localparam int LDSS_C0_REF_BIT = 0;
  localparam int LDSS_C0_INP_BIT = 1;
  localparam int LDSS_C0_FILT_BIT = 2;
  localparam int LDSS_C0_DIR1_BIT = 3;
  localparam int LDSS_C0_DIR2_BIT = 4;
  // Control 1 / 2 row-direct select position
  localparam int LDSS_ROW_SEL_BIT = 7;
  // Control 5 field positions
  localparam int LDSS_C5_FS1_LO = 0;
  localparam int LDSS_C5_FS2_LO = 2;
  localparam int LDSS_C5_DAC1_BIT = 6;
  localparam int LDSS_C5_DAC2_BIT = 7;

  localparam logic [7:0] LDSS_CTRL_RST = 8'h00;
  localparam logic [7:0] LDSS_DAC_HOLD = 8'h00;
  localparam logic [2:0] LDSS_MATCH_NEED = 3'h4;

  typedef struct packed {
    logic ref_source_sel;
    logic conv_input_sel;
    logic result_filter_disable;
    logic ch1_direction_sel;
    logic ch2_direction_sel;
    logic [1:0] ch1_fullscale;
    logic [1:0] ch2_fullscale;
  } ldss_analog_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ldss_conv_s;

endpackage

/* File: hw/ldss_top.sv */
/*
  Digital control path of the dual table current-DAC controller:
  result filter, result byte, table row selection, DAC source muxing
  and power-up hold. Assumes a free-running converter that presents one
  result per valid pulse, and a recall engine that preloads the
  control and table storage and raises recall_done_i before analog
  power-up.
// How it works
// RL1: result readable at 87h, writes ignored
// RL2: result is plain binary, 00h min to FFh max
// RL3: filter on: publish after four results share top six bits
// RL4: filter off: publish every conversion
// RL5: reference select bit in control 0, zero internal
// RL6: input select bit in control 0, zero internal sensor
// RL7: two 64-byte tables, output is the selected row
// RL8: row address is base 90h or D0h plus six-bit index
// RL9: default row index is result top six bits
// RL10: row-direct bit picks low six bits of control 1 or 2
// RL11: both bits zero: DAC takes the converter-addressed row
// RL12: DAC-direct bit picks control 3 or 4 byte
// RL13: one result feeds both channels, channels independent
// RL14: per-channel direction bit in control 0
// RL15: two-bit full-scale field per channel
// RL16: recall control bits first, then power analog
// RL17: DACs held at 00h until first qualified result
// RL18: filter off: one conversion releases the hold
// RL19: recalled select bits govern the first DAC source
// RL20: channel two DAC-direct bit is control 5 bit 7
// RL21: converter runs continuously without trigger
*/
`timescale 1ns/100ps
module ldss_top
  import ldss_pkg::*;
#(
  parameter int TAB_ROWS = 64
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic recall_done_i,
  input wire ldss_conv_s conv_i,
  output logic conv_enable_o,
  output logic analog_pwr_o,
  output ldss_analog_s analog_o,
  output logic [7:0] dac1_o,
  output logic [7:0] dac2_o
);

  typedef enum logic [2:0]
  {
    ST_RECALL = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } ldss_state_e;

  ldss_state_e state_ff;
  ldss_state_e nxt_state;
  logic [7:0] ctrl_ff [0:5];
  logic [7:0] tab1_ff [0:TAB_ROWS-1];
  logic [7:0] tab2_ff [0:TAB_ROWS-1];
  logic [7:0] result_ff;
  logic [5:0] prev_top_ff;
  logic [2:0] match_ff;
  logic [2:0] nxt_match;
  logic [7:0] rdata_ff;
  logic [7:0] dac1_ff;
  logic [7:0] dac2_ff;

  function automatic logic [7:0] pick_dac(
    input logic dac_sel,
    input logic [7:0] direct_byte,
    input logic [7:0] row_byte
  );
    pick_dac = dac_sel ? direct_byte : row_byte;
  endfunction

  function automatic logic [5:0] pick_row(
    input logic row_sel,
    input logic [7:0] ctrl_byte,
    input logic [5:0] conv_row
  );
    pick_row = row_sel ? ctrl_byte[5:0] : conv_row;
  endfunction

  // Inclusive address span test
  function automatic logic in_span(
    input logic [8:0] addr,
    input logic [8:0] lo,
    input logic [8:0] hi
  );
    in_span = (addr >= lo) && (addr <= hi);
  endfunction

  wire logic filt_off = ctrl_ff[0][LDSS_C0_FILT_BIT];
  wire logic [5:0] new_top = conv_i.data[7:2];
  wire logic top_same = (new_top == prev_top_ff);
  // RL3: four results matching in top six bits
  assign nxt_match = !top_same ? 3'h1 :
    (match_ff == LDSS_MATCH_NEED) ? match_ff : match_ff + 3'h1;
  // Results arriving during recall are dropped
  wire logic take_conv = conv_i.valid && (state_ff != ST_RECALL);
  // RL4: filter bypass
  wire logic publish = take_conv &&
    (filt_off || nxt_match == LDSS_MATCH_NEED);

  // RL9: converter top six bits
  wire logic [5:0] conv_row = result_ff[7:2];
  // RL10: row-direct override
  wire logic [5:0] row1 = pick_row(ctrl_ff[1][LDSS_ROW_SEL_BIT],
    ctrl_ff[1], conv_row);
  wire logic [5:0] row2 = pick_row(ctrl_ff[2][LDSS_ROW_SEL_BIT],
    ctrl_ff[2], conv_row);
  // RL8: base plus row index
  wire logic [8:0] row1_addr = LDSS_TAB1_BASE + {3'h0, row1};
  wire logic [8:0] row2_addr = LDSS_TAB2_BASE + {3'h0, row2};
  // RL7: table outputs at selected row
  wire logic [5:0] tab1_row = 6'(row1_addr - LDSS_TAB1_BASE);
  wire logic [5:0] tab2_row = 6'(row2_addr - LDSS_TAB2_BASE);
  wire logic [7:0] tab1_out = tab1_ff[tab1_row];
  wire logic [7:0] tab2_out = tab2_ff[tab2_row];
  // RL11: default table source
  // RL12: direct byte overrides
  // RL13: channels independent
  // RL20: channel two bit at control 5 bit 7
  wire logic [7:0] dac1_src = pick_dac(ctrl_ff[5][LDSS_C5_DAC1_BIT],
    ctrl_ff[3], tab1_out);
  wire logic [7:0] dac2_src = pick_dac(ctrl_ff[5][LDSS_C5_DAC2_BIT],
    ctrl_ff[4], tab2_out);

  // Address decode shared by write and read paths
  wire logic hit_result = (reg_addr_i == LDSS_RESULT_OFS);
  wire logic hit_ctrl = in_span(reg_addr_i, LDSS_CTRL0_OFS, LDSS_CTRL5_OFS);
  wire logic hit_tab1 = in_span(reg_addr_i, LDSS_TAB1_BASE,
    LDSS_TAB2_BASE - 9'h001);
  wire logic hit_tab2 = in_span(reg_addr_i, LDSS_TAB2_BASE, LDSS_TAB2_END);
  wire logic wr_ctrl = reg_wr_i && hit_ctrl;
  wire logic wr_tab1 = reg_wr_i && hit_tab1;
  wire logic wr_tab2 = reg_wr_i && hit_tab2;
  wire logic [2:0] ctrl_idx = 3'(reg_addr_i - LDSS_CTRL0_OFS);
  wire logic [5:0] tab1_idx = 6'(reg_addr_i - LDSS_TAB1_BASE);
  wire logic [5:0] tab2_idx = 6'(reg_addr_i - LDSS_TAB2_BASE);

  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    // RL1: read-only result
    if (hit_result)
    begin
      rd_mux = result_ff;
    end
    else if (hit_ctrl)
    begin
      rd_mux = ctrl_ff[ctrl_idx];
    end
    else if (hit_tab1)
    begin
      rd_mux = tab1_ff[tab1_idx];
    end
    else if (hit_tab2)
    begin
      rd_mux = tab2_ff[tab2_idx];
    end
  end

  // RL16: recall before analog power
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RECALL:
      begin
        if (recall_done_i)
        begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // RL17: first qualified result
        // RL18: one conversion when filter off
        if (publish)
        begin
          nxt_state = ST_RUN;
        end
      end
      default:
      begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_RECALL;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 6; i++)
      begin
        ctrl_ff[i] <= LDSS_CTRL_RST;
      end
    end
    else if (wr_ctrl)
    begin
      ctrl_ff[ctrl_idx] <= reg_wdata_i;
    end
  end

  // Table one storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < TAB_ROWS; i++)
      begin
        tab1_ff[i] <= 8'h00;
      end
    end
    else if (wr_tab1)
    begin
      tab1_ff[tab1_idx] <= reg_wdata_i;
    end
  end

  // Table two storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < TAB_ROWS; i++)
      begin
        tab2_ff[i] <= 8'h00;
      end
    end
    else if (wr_tab2)
    begin
      tab2_ff[tab2_idx] <= reg_wdata_i;
    end
  end

  // RL21: continuous conversion feed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_top_ff <= 6'h00;
      match_ff <= 3'h0;
    end
    else if (take_conv)
    begin
      prev_top_ff <= new_top;
      match_ff <= nxt_match;
    end
  end

  // RL2: plain binary result
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_ff <= 8'h00;
    end
    else if (publish)
    begin
      result_ff <= conv_i.data;
    end
  end

  // Read data for one cycle, zero when idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

  wire logic dac_run = (state_ff == ST_RUN);
  // RL17: hold DACs at zero
  // RL19: recalled selects from first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac1_ff <= LDSS_DAC_HOLD;
    end
    else
    begin
      dac1_ff <= dac_run ? dac1_src : LDSS_DAC_HOLD;
    end
  end

  // Channel two output byte
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dac2_ff <= LDSS_DAC_HOLD;
    end
    else
    begin
      dac2_ff <= dac_run ? dac2_src : LDSS_DAC_HOLD;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign dac1_o = dac1_ff;
  assign dac2_o = dac2_ff;
  assign conv_enable_o = (state_ff != ST_RECALL);
  assign analog_pwr_o = (state_ff != ST_RECALL);
  // RL5: reference select
  assign analog_o.ref_source_sel = ctrl_ff[0][LDSS_C0_REF_BIT];
  // RL6: input select
  assign analog_o.conv_input_sel = ctrl_ff[0][LDSS_C0_INP_BIT];
  assign analog_o.result_filter_disable = filt_off;
  // RL14: per-channel direction
  assign analog_o.ch1_direction_sel = ctrl_ff[0][LDSS_C0_DIR1_BIT];
  assign analog_o.ch2_direction_sel = ctrl_ff[0][LDSS_C0_DIR2_BIT];
  // RL15: full-scale fields
  assign analog_o.ch1_fullscale = ctrl_ff[5][LDSS_C5_FS1_LO +: 2];
  assign analog_o.ch2_fullscale = ctrl_ff[5][LDSS_C5_FS2_LO +: 2];

endmodule

/* File: sim/ldss_top_sva.sv */
/* Port checker for ldss_top.
   Bound to each ldss_top; sees its ports only. */
`timescale 1ns/100ps
module ldss_top_sva
  import ldss_pkg::*;
#(
  parameter int TAB_ROWS = 64
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [8:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic recall_done_i,
  input wire ldss_conv_s conv_i,
  input wire logic conv_enable_o,
  input wire logic analog_pwr_o,
  input wire ldss_analog_s analog_o,
  input wire logic [7:0] dac1_o,
  input wire logic [7:0] dac2_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_off_conv;
    conv_i.valid && conv_enable_o && analog_o.result_filter_disable;
  endsequence
  sequence s_res_rd;
    reg_rd_i && reg_addr_i == LDSS_RESULT_OFS && !conv_i.valid;
  endsequence
  property p_filt_off;
    s_off_conv ##1 !conv_i.valid ##1 s_res_rd
      |=> reg_rdata_o == $past(conv_i.data, 3);
  endproperty
  a_filt_off: assert property (p_filt_off) else $error("bad result");
  property p_rd_idle;
    reg_rdata_o != 8'h00 |-> $past(reg_rd_i);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  property p_unmapped;
    reg_rd_i && reg_addr_i == 9'h088 |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved");
  property p_dac_hold;
    !conv_enable_o |-> dac1_o == LDSS_DAC_HOLD && dac2_o == LDSS_DAC_HOLD;
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("no hold");
  property p_pwr;
    $rose(analog_pwr_o) |-> $past(recall_done_i);
  endproperty
  a_pwr: assert property (p_pwr) else $error("early power");
  property p_conv_en;
    conv_enable_o |-> analog_pwr_o;
  endproperty
  a_conv_en: assert property (p_conv_en) else $error("early conv");
  property p_ctrl0;
    reg_wr_i && reg_addr_i == LDSS_CTRL0_OFS |=>
      analog_o.ref_source_sel == $past(reg_wdata_i[0]) &&
      analog_o.ch1_direction_sel == $past(reg_wdata_i[3]);
  endproperty
  a_ctrl0: assert property (p_ctrl0) else $error("ctrl0");
  property p_fs;
    reg_wr_i && reg_addr_i == LDSS_CTRL5_OFS |=>
      analog_o.ch1_fullscale == $past(reg_wdata_i[1:0]) &&
      analog_o.ch2_fullscale == $past(reg_wdata_i[3:2]);
  endproperty
  a_fs: assert property (p_fs) else $error("full scale");
endmodule

bind ldss_top ldss_top_sva #(.TAB_ROWS(TAB_ROWS)) u_ldss_top_sva (
  .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .recall_done_i(recall_done_i),
  .conv_i(conv_i), .conv_enable_o(conv_enable_o),
  .analog_pwr_o(analog_pwr_o), .analog_o(analog_o),
  .dac1_o(dac1_o), .dac2_o(dac2_o));

/* File: sim/ldss_top_tb_top.sv */
/* Bench for ldss_top: register and converter tasks, checks.
   Assumes ldss_pkg and the checker are compiled first. */
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module ldss_top_tb_top import ldss_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i, reg_wr_i, reg_rd_i, recall_done_i, conv_enable_o, analog_pwr_o;
  logic [8:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, dac1_o, dac2_o;
  ldss_conv_s conv_i;
  ldss_analog_s analog_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  ldss_top u_ldss_top (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .recall_done_i(recall_done_i), .conv_i(conv_i),
    .conv_enable_o(conv_enable_o), .analog_pwr_o(analog_pwr_o),
    .analog_o(analog_o), .dac1_o(dac1_o), .dac2_o(dac2_o));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  task automatic cv(input logic [7:0] d);
    @(posedge clk_i);
    conv_i <= '{1'b1, d};
    @(posedge clk_i);
    conv_i.valid <= 1'b0;
  endtask
  task automatic dchk(input logic [7:0] e1, input logic [7:0] e2);
    repeat (2) @(posedge clk_i);
    #1 `CHK(dac1_o, e1)
    `CHK(dac2_o, e2)
  endtask
  task automatic restart;
    @(posedge clk_i);
    rst_i <= 1'b1;
    recall_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic go;
    @(posedge clk_i);
    recall_done_i <= 1'b1;
  endtask
  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      complete_run;
    end
  end
  initial
  begin
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, recall_done_i} = 3'h0;
    reg_addr_i = 9'h000;
    reg_wdata_i = 8'h00;
    conv_i = '0;
    restart;
    wr(9'h0BA, 8'h5A);
    wr(9'h0FA, 8'hA5);
    wr(9'h095, 8'h33);
    wr(9'h10F, 8'hC3);
    repeat (4) cv(8'hAA);
    dchk(8'h00, 8'h00);
    go;
    repeat (3) cv(8'hAA);
    dchk(8'h00, 8'h00);
    cv(8'hAA);
    dchk(8'h5A, 8'hA5);
    rdc(9'h087, 8'hAA);
    wr(9'h087, 8'h12);
    rdc(9'h087, 8'hAA);
    rdc(9'h088, 8'h00);
    repeat (3) cv(8'h10);
    repeat (3) cv(8'h14);
    rdc(9'h087, 8'hAA);
    cv(8'h14);
    rdc(9'h087, 8'h14);
    dchk(8'h33, 8'h00);
    $display("test hold and filter done");
    wr(9'h080, 8'h1F);
    wr(9'h085, 8'h0E);
    `CHK(analog_o, 9'h1FB)
    cv(8'hFF);
    rdc(9'h087, 8'hFF);
    dchk(8'h00, 8'hC3);
    cv(8'h00);
    rdc(9'h087, 8'h00);
    $display("test unfiltered done");
    wr(9'h081, 8'h85);
    dchk(8'h33, 8'h00);
    wr(9'h082, 8'hBF);
    dchk(8'h33, 8'hC3);
    wr(9'h083, 8'h77);
    wr(9'h084, 8'h88);
    wr(9'h085, 8'hCE);
    dchk(8'h77, 8'h88);
    wr(9'h085, 8'h4E);
    dchk(8'h77, 8'hC3);
    $display("test source select done");
    restart;
    wr(9'h080, 8'h04);
    wr(9'h083, 8'h66);
    wr(9'h085, 8'h40);
    `CHK(analog_pwr_o, 1'b0)
    go;
    dchk(8'h00, 8'h00);
    `CHK(conv_enable_o, 1'b1)
    `CHK(analog_pwr_o, 1'b1)
    cv(8'h00);
    dchk(8'h66, 8'h00);
    $display("test power-up select done");
    complete_run;
  end
endmodule
